// ---- sc_exec_defines.svh ----
/*
 * Constants of the set/clear and block check execution block: opcode values,
 * bit positions and timing counts. Assumes a 40 MHz core clock.
 */
// Overview of operation
// - on set/clear, decode code bits 07..00 into at most one action; unused codes give none.
// - the set/clear action pulse is issued at the data strobe phase only.
// - codes 08-0F set receiver bits, set status bits, clear status 08, clear nxm.
// - codes 10-17 drive silo out/in, receive enable, alu bit 02/01 and high byte.
// - codes 20-27 and 80-87 clear (even) or set (odd) ram output data bits.
// - codes 42-47 advance scanner, resync, clear/set transmit mark and data bit 08.
// - block check selects one of four resultants by ram output bits 04 and 03.
// - resultants are combinational functions of current A and B operands.
// - selected resultant loads the 16-bit block check register at data strobe.
// - silo input action gives a write pulse of 180 ns rounded up to whole clocks (8 cycles, 200 ns) into the silo top.
// - resync flag set by set/clear command, cleared at next scanner advance.
`ifndef SC_EXEC_DEFINES_SVH
`define SC_EXEC_DEFINES_SVH

`define SC_RCV15 8'h08
`define SC_RCV14 8'h09
`define SC_STAT10 8'h0A
`define SC_STAT07 8'h0B
`define SC_RCV12 8'h0C
`define SC_RCV13 8'h0D
`define SC_STAT_CLR08 8'h0E
`define SC_NXM_CLR 8'h0F
`define SC_SILO_OUT 8'h10
`define SC_SILO_IN 8'h11
`define SC_RDE_CLR 8'h12
`define SC_RDE_SET 8'h13
`define SC_ALU_SET02 8'h14
`define SC_ALU_CLR02 8'h15
`define SC_ALU_CLR01 8'h16
`define SC_ALU_CLR_HI 8'h17
`define SC_SCAN_ADV 8'h42
`define SC_RESYNC 8'h43
`define SC_TRANSMIT_MARK_CLR 8'h44
`define SC_TRANSMIT_MARK_SET 8'h45
`define SC_TD08_CLR 8'h46
`define SC_TD08_SET 8'h47
`define SC_RAM_LO_NIB 4'h2
`define SC_RAM_HI_NIB 4'h8

`define RAM_SEL_LO_POS 3
`define RAM_SEL_HI_POS 4

`define CORE_CLK_PERIOD_NS 25
`define SILO_IN_PULSE_NS 180
`define SILO_IN_PULSE_CYC ((`SILO_IN_PULSE_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

`define BC_RESET_VAL 16'h0000

`endif

// ---- sc_exec_pkg.sv ----
/*
 * Types of the set/clear and block check execution block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sc_exec_pkg;

	typedef logic [15:0] word_type;

	typedef enum logic [1:0] {
		BC_SEL_XOR = 2'h0,
		BC_SEL_A = 2'h1,
		BC_SEL_B = 2'h2,
		BC_SEL_XNOR = 2'h3
	} bc_sel_type;

	typedef enum logic [4:0] {
		ACT_NONE = 5'h00,
		ACT_RCV15 = 5'h01,
		ACT_RCV14 = 5'h02,
		ACT_STAT10 = 5'h03,
		ACT_STAT07 = 5'h04,
		ACT_RCV12 = 5'h05,
		ACT_RCV13 = 5'h06,
		ACT_STAT_CLR08 = 5'h07,
		ACT_NXM_CLR = 5'h08,
		ACT_SILO_OUT = 5'h09,
		ACT_SILO_IN = 5'h0A,
		ACT_RDE_CLR = 5'h0B,
		ACT_RDE_SET = 5'h0C,
		ACT_ALU_SET02 = 5'h0D,
		ACT_ALU_CLR02 = 5'h0E,
		ACT_ALU_CLR01 = 5'h0F,
		ACT_ALU_CLR_HI = 5'h10,
		ACT_RAM = 5'h11,
		ACT_SCAN_ADV = 5'h12,
		ACT_RESYNC = 5'h13,
		ACT_TRANSMIT_MARK_CLR = 5'h14,
		ACT_TRANSMIT_MARK_SET = 5'h15,
		ACT_TD08_CLR = 5'h16,
		ACT_TD08_SET = 5'h17
	} action_type;

endpackage

// ---- bc_net_if.sv ----
/*
 * Interface between the execution block and its block check network.
 * Assumes both ends sit on the same core clock.
 */
`timescale 1ns/1ps
interface bc_net_if;
	import sc_exec_pkg::*;
	word_type a;
	word_type b;
	bc_sel_type sel;
	word_type result;
	modport net (input a, input b, input sel, output result);
	modport user (output a, output b, output sel, input result);
endinterface // bc_net_if

// ---- bc_net.sv ----
/*
 * Block check network: four resultants formed from the A and B operands,
 * one picked by the selector. Purely combinational; the caller registers it.
 */
`timescale 1ns/1ps
module bc_net
	import sc_exec_pkg::*;
(
	bc_net_if.net bus
);
	always_comb begin
		unique case (bus.sel)
			BC_SEL_XOR: bus.result = bus.a ^ bus.b;
			BC_SEL_A: bus.result = bus.a;
			BC_SEL_B: bus.result = bus.b;
			BC_SEL_XNOR: bus.result = ~(bus.a ^ bus.b);
		endcase
	end
endmodule // bc_net

// ---- sc_exec.sv ----
/*
 * Set/clear and block check execution. Decodes the set/clear code into one
 * registered action pulse at data strobe, holds the level flags that it owns,
 * and loads the block check result register.
 * Assumes sc_exec_i, bc_exec_i, code_i and data_strobe_i come from the
 * sequencer on core_clk_i and stay valid through the strobe cycle.
 */
`timescale 1ns/1ps
`include "sc_exec_defines.svh"
module sc_exec
	import sc_exec_pkg::*;
#(
	parameter int SILO_IN_CYC = `SILO_IN_PULSE_CYC
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic data_strobe_i,
	input wire logic sc_exec_i,
	input wire logic bc_exec_i,
	input wire logic [7:0] code_i,
	input wire logic [7:0] ram_out_data_i,
	input wire logic [15:0] a_reg_i,
	input wire logic [15:0] b_reg_i,
	output logic [3:0] rcv_ctl_set_o,
	output logic stat_ctl_set10_o,
	output logic stat_ctl_set07_o,
	output logic stat_ctl_clr08_o,
	output logic nonexistent_memory_flag_clr_o,
	output logic silo_shift_out_o,
	output logic silo_load_in_o,
	output logic receive_data_enable_o,
	output logic alu_set02_o,
	output logic alu_clr02_o,
	output logic alu_clr01_o,
	output logic alu_clr_high_o,
	output logic [7:0] ram_set_o,
	output logic [7:0] ram_clr_o,
	output logic scan_advance_o,
	output logic resync_pulse_o,
	output logic resync_flag_o,
	output logic transmit_mark_o,
	output logic tran_data08_o,
	output logic [15:0] block_check_o
);

	// the pulse counter is eight bits wide
	if (SILO_IN_CYC < 1 || SILO_IN_CYC > 255) begin : g_bad_silo_cyc
		$error("SILO_IN_CYC out of range");
	end

	function automatic action_type decode_sc(input logic [7:0] code);
		action_type act;
		act = ACT_NONE;
		unique case (code)
			`SC_RCV15: act = ACT_RCV15;
			`SC_RCV14: act = ACT_RCV14;
			`SC_STAT10: act = ACT_STAT10;
			`SC_STAT07: act = ACT_STAT07;
			`SC_RCV12: act = ACT_RCV12;
			`SC_RCV13: act = ACT_RCV13;
			`SC_STAT_CLR08: act = ACT_STAT_CLR08;
			`SC_NXM_CLR: act = ACT_NXM_CLR;
			`SC_SILO_OUT: act = ACT_SILO_OUT;
			`SC_SILO_IN: act = ACT_SILO_IN;
			`SC_RDE_CLR: act = ACT_RDE_CLR;
			`SC_RDE_SET: act = ACT_RDE_SET;
			`SC_ALU_SET02: act = ACT_ALU_SET02;
			`SC_ALU_CLR02: act = ACT_ALU_CLR02;
			`SC_ALU_CLR01: act = ACT_ALU_CLR01;
			`SC_ALU_CLR_HI: act = ACT_ALU_CLR_HI;
			`SC_SCAN_ADV: act = ACT_SCAN_ADV;
			`SC_RESYNC: act = ACT_RESYNC;
			`SC_TRANSMIT_MARK_CLR: act = ACT_TRANSMIT_MARK_CLR;
			`SC_TRANSMIT_MARK_SET: act = ACT_TRANSMIT_MARK_SET;
			`SC_TD08_CLR: act = ACT_TD08_CLR;
			`SC_TD08_SET: act = ACT_TD08_SET;
			default: begin
				if (code[3] == 1'b0 &&
						(code[7:4] == `SC_RAM_LO_NIB || code[7:4] == `SC_RAM_HI_NIB))
					act = ACT_RAM;
			end
		endcase
		return act;
	endfunction

	// ram bit index: low codes 0-1 map to bit 3 (or 7), 6-7 to bit 0 (or 4)
	function automatic logic [7:0] ram_bit_mask(input logic [7:0] code);
		logic [2:0] idx;
		idx = {code[7], ~code[2:1]};
		return 8'h01 << idx;
	endfunction

	action_type act;
	logic fire;
	logic bc_fire;
	logic [7:0] silo_cnt_r;
	logic [7:0] silo_cnt_nxt;

	assign act = decode_sc(code_i);
	assign fire = sc_exec_i && data_strobe_i;
	assign bc_fire = bc_exec_i && data_strobe_i;

	bc_net_if bc_bus ();
	assign bc_bus.a = a_reg_i;
	assign bc_bus.b = b_reg_i;
	assign bc_bus.sel = bc_sel_type'({ram_out_data_i[`RAM_SEL_HI_POS],
		ram_out_data_i[`RAM_SEL_LO_POS]});

	bc_net bc_net_i (
		.bus(bc_bus)
	);

	// one-cycle action pulses
	always_ff @(posedge core_clk_i) begin
		rcv_ctl_set_o <= 4'h0;
		stat_ctl_set10_o <= 1'b0;
		stat_ctl_set07_o <= 1'b0;
		stat_ctl_clr08_o <= 1'b0;
		nonexistent_memory_flag_clr_o <= 1'b0;
		silo_shift_out_o <= 1'b0;
		alu_set02_o <= 1'b0;
		alu_clr02_o <= 1'b0;
		alu_clr01_o <= 1'b0;
		alu_clr_high_o <= 1'b0;
		ram_set_o <= 8'h00;
		ram_clr_o <= 8'h00;
		scan_advance_o <= 1'b0;
		resync_pulse_o <= 1'b0;
		if (!srst_i && fire) begin
			unique case (act)
				ACT_RCV15: rcv_ctl_set_o[3] <= 1'b1;
				ACT_RCV14: rcv_ctl_set_o[2] <= 1'b1;
				ACT_RCV13: rcv_ctl_set_o[1] <= 1'b1;
				ACT_RCV12: rcv_ctl_set_o[0] <= 1'b1;
				ACT_STAT10: stat_ctl_set10_o <= 1'b1;
				ACT_STAT07: stat_ctl_set07_o <= 1'b1;
				ACT_STAT_CLR08: stat_ctl_clr08_o <= 1'b1;
				ACT_NXM_CLR: nonexistent_memory_flag_clr_o <= 1'b1;
				ACT_SILO_OUT: silo_shift_out_o <= 1'b1;
				ACT_ALU_SET02: alu_set02_o <= 1'b1;
				ACT_ALU_CLR02: alu_clr02_o <= 1'b1;
				ACT_ALU_CLR01: alu_clr01_o <= 1'b1;
				ACT_ALU_CLR_HI: alu_clr_high_o <= 1'b1;
				ACT_RAM: begin
					if (code_i[0])
						ram_set_o <= ram_bit_mask(code_i);
					else
						ram_clr_o <= ram_bit_mask(code_i);
				end
				ACT_SCAN_ADV: scan_advance_o <= 1'b1;
				ACT_RESYNC: resync_pulse_o <= 1'b1;
				default: begin
				end
			endcase
		end
	end

	// silo input write pulse stretched to its full width
	always_comb begin
		silo_cnt_nxt = silo_cnt_r;
		if (fire && act == ACT_SILO_IN)
			silo_cnt_nxt = 8'(SILO_IN_CYC);
		else if (silo_cnt_r != 8'h00)
			silo_cnt_nxt = silo_cnt_r - 8'h01;
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			silo_cnt_r <= 8'h00;
			silo_load_in_o <= 1'b0;
		end else begin
			silo_cnt_r <= silo_cnt_nxt;
			silo_load_in_o <= (silo_cnt_nxt != 8'h00);
		end
	end

	// receive data enable level
	always_ff @(posedge core_clk_i) begin
		if (srst_i)
			receive_data_enable_o <= 1'b0;
		else if (fire && act == ACT_RDE_SET)
			receive_data_enable_o <= 1'b1;
		else if (fire && act == ACT_RDE_CLR)
			receive_data_enable_o <= 1'b0;
	end

	// resync flag: set by command, cleared by next scanner advance
	always_ff @(posedge core_clk_i) begin
		if (srst_i)
			resync_flag_o <= 1'b0;
		else if (fire && act == ACT_RESYNC)
			resync_flag_o <= 1'b1;
		else if (fire && act == ACT_SCAN_ADV)
			resync_flag_o <= 1'b0;
	end

	// transmit mark and transmit data bit 08 levels
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			transmit_mark_o <= 1'b0;
			tran_data08_o <= 1'b0;
		end else if (fire) begin
			if (act == ACT_TRANSMIT_MARK_SET)
				transmit_mark_o <= 1'b1;
			else if (act == ACT_TRANSMIT_MARK_CLR)
				transmit_mark_o <= 1'b0;
			if (act == ACT_TD08_SET)
				tran_data08_o <= 1'b1;
			else if (act == ACT_TD08_CLR)
				tran_data08_o <= 1'b0;
		end
	end

	// block check result register
	always_ff @(posedge core_clk_i) begin
		if (srst_i)
			block_check_o <= `BC_RESET_VAL;
		else if (bc_fire)
			block_check_o <= bc_bus.result;
	end

	logic [30:0] pulse_vec;
	assign pulse_vec = {rcv_ctl_set_o, stat_ctl_set10_o, stat_ctl_set07_o,
		stat_ctl_clr08_o, nonexistent_memory_flag_clr_o, silo_shift_out_o,
		alu_set02_o, alu_clr02_o, alu_clr01_o, alu_clr_high_o, ram_set_o,
		ram_clr_o, scan_advance_o, resync_pulse_o};

	a_one_action_pulse: assert property (@(posedge core_clk_i) disable iff (srst_i)
		$onehot0(pulse_vec))
		else $error("more than one action pulse");

	a_pulse_needs_strobe: assert property (@(posedge core_clk_i) disable iff (srst_i)
		(pulse_vec != 31'h00000000) |-> $past(fire))
		else $error("action pulse without data strobe");

	a_rcv15_decode: assert property (@(posedge core_clk_i) disable iff (srst_i)
		fire && code_i == 8'h08 |=> rcv_ctl_set_o == 4'h8)
		else $error("code 08 did not set receiver bit 15");

	a_rde_set_level: assert property (@(posedge core_clk_i) disable iff (srst_i)
		fire && code_i == 8'h13 |=> receive_data_enable_o)
		else $error("receive enable not set");

	a_ram_bit_map: assert property (@(posedge core_clk_i) disable iff (srst_i)
		fire && code_i == 8'h87 |=> ram_set_o == 8'h10 && ram_clr_o == 8'h00)
		else $error("code 87 did not set ram bit 04");

	a_scan_adv_only: assert property (@(posedge core_clk_i) disable iff (srst_i)
		fire && code_i == 8'h42 |=> scan_advance_o && !resync_pulse_o)
		else $error("scanner advance missing");

	a_bc_select_load: assert property (@(posedge core_clk_i) disable iff (srst_i)
		bc_fire && ram_out_data_i[4:3] == 2'h1 |=> block_check_o == $past(a_reg_i))
		else $error("block check did not load A resultant");

	// assertion helper: cycles since the last silo input command, saturating
	logic [8:0] silo_age_r;

	always_ff @(posedge core_clk_i) begin
		if (srst_i)
			silo_age_r <= 9'h000;
		else if (fire && act == ACT_SILO_IN)
			silo_age_r <= 9'h001;
		else if (silo_age_r != 9'h000 && silo_age_r != 9'h1FF)
			silo_age_r <= silo_age_r + 9'h001;
	end

	a_silo_pulse_width: assert property (@(posedge core_clk_i) disable iff (srst_i)
		silo_load_in_o == (silo_age_r != 9'h000 && silo_age_r <= 9'(SILO_IN_CYC)))
		else $error("silo input pulse width wrong");

	a_resync_cleared: assert property (@(posedge core_clk_i) disable iff (srst_i)
		fire && code_i == 8'h42 |=> !resync_flag_o)
		else $error("resync flag not cleared by scanner advance");

	a_unused_no_op: assert property (@(posedge core_clk_i) disable iff (srst_i)
		fire && (code_i == 8'h40 || code_i == 8'h41) && !bc_fire
			|=> pulse_vec == 31'h00000000 && $stable(receive_data_enable_o)
			&& $stable(transmit_mark_o) && $stable(resync_flag_o))
		else $error("unused code caused an action");

endmodule // sc_exec

// ---- sc_seq_model.sv ----
/*
 * Sequencer timing model: a four-cycle microcycle with the data strobe in its
 * last cycle. Assumes the core clock and synchronous reset of the block.
 */
`timescale 1ns/1ps
module sc_seq_model (
	input wire logic core_clk_i,
	input wire logic srst_i,
	output logic [1:0] phase_o,
	output logic data_strobe_o
);
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			phase_o <= 2'h0;
		end else begin
			phase_o <= phase_o + 2'h1;
		end
	end
	// strobe only in the last phase
	assign data_strobe_o = (phase_o == 2'h3);
endmodule // sc_seq_model

// ---- sc_exec_tb.sv ----
/*
 * Self-checking bench of sc_exec, with the sequencer model as strobe source.
 * Assumes the silo pulse parameter is set to 2 cycles here.
 */
`timescale 1ns/1ps
module sc_exec_tb;
	import sc_exec_pkg::*;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic sc_op = 1'b0;
	logic bc_op = 1'b0;
	logic [7:0] code_i = 8'h00;
	logic [7:0] ram_i = 8'h00;
	word_type a_i = 16'h0000;
	word_type b_i = 16'h0000;
	logic strobe;
	logic [1:0] phase;
	logic [3:0] rcv;
	logic s10, s07, c08, nonexistent_memory_flag, sh, ld, receive_data_enable, a2s, a2c, a1c, ahi, scan, rsp, rsf, tm, td;
	logic [7:0] rset, rclr;
	word_type bcc;
	int n_fail = 0;
	int n_tests = 0;
	logic [3:0] lvl_exp = 4'h0;
	word_type bc_exp = 16'h0000;
	wire logic [31:0] pul = {rcv, s10, s07, c08, nonexistent_memory_flag, sh, ld, a2s, a2c, a1c, ahi, rset, rclr, scan, rsp};
	wire logic [3:0] lvl = {receive_data_enable, tm, td, rsf};

	always #12.5 core_clk_i = ~core_clk_i;

	sc_seq_model sc_seq_model_i (.core_clk_i(core_clk_i), .srst_i(srst_i), .phase_o(phase),
		.data_strobe_o(strobe));
	sc_exec #(.SILO_IN_CYC(2)) sc_exec_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.data_strobe_i(strobe), .sc_exec_i(sc_op), .bc_exec_i(bc_op), .code_i(code_i),
		.ram_out_data_i(ram_i), .a_reg_i(a_i), .b_reg_i(b_i), .rcv_ctl_set_o(rcv),
		.stat_ctl_set10_o(s10), .stat_ctl_set07_o(s07), .stat_ctl_clr08_o(c08),
		.nonexistent_memory_flag_clr_o(nonexistent_memory_flag), .silo_shift_out_o(sh), .silo_load_in_o(ld),
		.receive_data_enable_o(receive_data_enable), .alu_set02_o(a2s), .alu_clr02_o(a2c), .alu_clr01_o(a1c),
		.alu_clr_high_o(ahi), .ram_set_o(rset), .ram_clr_o(rclr), .scan_advance_o(scan),
		.resync_pulse_o(rsp), .resync_flag_o(rsf), .transmit_mark_o(tm),
		.tran_data08_o(td), .block_check_o(bcc));

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	function automatic logic [31:0] exp_pul(input logic [7:0] c);
		logic [31:0] e;
		e = 32'h0;
		if (c[7:3] == 5'h01) begin
			case (c[2:0])
				3'h0: e[31] = 1'b1;
				3'h1: e[30] = 1'b1;
				3'h2: e[27] = 1'b1;
				3'h3: e[26] = 1'b1;
				3'h4: e[28] = 1'b1;
				3'h5: e[29] = 1'b1;
				3'h6: e[25] = 1'b1;
				default: e[24] = 1'b1;
			endcase
		end
		if (c[7:3] == 5'h02 && c[2:0] != 3'h2 && c[2:0] != 3'h3) begin
			e[(c[2:0] < 3'h2) ? 23 - c[2:0] : 25 - c[2:0]] = 1'b1;
		end
		if ((c[7:4] == 4'h2 || c[7:4] == 4'h8) && !c[3]) begin
			e[(c[0] ? 10 : 2) + (c[7] ? 7 : 3) - c[2:1]] = 1'b1;
		end
		if (c == 8'h42) e[1] = 1'b1;
		if (c == 8'h43) e[0] = 1'b1;
		return e;
	endfunction

	function automatic logic [3:0] lvl_nxt(input logic [7:0] c, input logic [3:0] l);
		logic [3:0] n;
		n = l;
		case (c)
			8'h12: n[3] = 1'b0;
			8'h13: n[3] = 1'b1;
			8'h44: n[2] = 1'b0;
			8'h45: n[2] = 1'b1;
			8'h46: n[1] = 1'b0;
			8'h47: n[1] = 1'b1;
			8'h42: n[0] = 1'b0;
			8'h43: n[0] = 1'b1;
			default: ;
		endcase
		return n;
	endfunction

	// one microcycle; outputs watched from issue to three cycles after the strobe
	task automatic micro(input logic sc, input logic bc, input logic [7:0] c);
		logic [31:0] pe;
		int k;
		pe = sc ? exp_pul(c) : 32'h0;
		do @(negedge core_clk_i); while (phase !== 2'h0);
		chk("levels before", {28'h0, lvl_exp}, {28'h0, lvl});
		if (sc) lvl_exp = lvl_nxt(c, lvl_exp);
		if (bc) begin
			case (ram_i[4:3])
				2'h0: bc_exp = a_i ^ b_i;
				2'h1: bc_exp = a_i;
				2'h2: bc_exp = b_i;
				default: bc_exp = ~(a_i ^ b_i);
			endcase
		end
		@(posedge core_clk_i);
		sc_op <= sc;
		bc_op <= bc;
		code_i <= c;
		for (k = 0; k < 6; k++) begin
			@(negedge core_clk_i);
			chk($sformatf("pulses code %h k %0d", c, k), (k == 3) ? pe :
				((k == 4) ? (pe & 32'h0040_0000) : 32'h0), pul);
			@(posedge core_clk_i);
			if (k == 2) begin
				sc_op <= 1'b0;
				bc_op <= 1'b0;
			end
		end
		@(negedge core_clk_i);
		chk("levels after", {28'h0, lvl_exp}, {28'h0, lvl});
		chk("block check", {16'h0, bc_exp}, {16'h0, bcc});
	endtask

	task automatic t_reset();
		@(negedge core_clk_i);
		chk("reset outputs", 32'h0, pul | {lvl, 28'h0} | {16'h0, bcc});
	endtask

	task automatic t_sweep();
		for (int c = 0; c < 256; c++) micro(1'b1, 1'b0, c[7:0]);
	endtask

	task automatic t_resync();
		micro(1'b1, 1'b0, 8'h43);
		micro(1'b1, 1'b0, 8'h42);
	endtask

	task automatic t_bcc();
		for (int s = 0; s < 4; s++) begin
			@(posedge core_clk_i);
			a_i <= 16'hC3A5 + s[15:0];
			b_i <= 16'h0FF0;
			ram_i <= {3'h5, s[1:0], 3'h6};
			micro(1'b0, 1'b1, 8'h45);
		end
		micro(1'b1, 1'b1, 8'h45);
	endtask

	initial begin
		#200000;
		n_fail++;
		test_done();
	end

	initial begin
		repeat (12) @(posedge core_clk_i);
		srst_i <= 1'b0;
		t_reset();
		t_sweep();
		t_resync();
		t_bcc();
		test_done();
	end
endmodule // sc_exec_tb
